/* File: dv/pdc_timer_model.sv */
// Partner model: free-running 8-bit period timer with prescaler bits
`timescale 1ns/10ps
module pdc_timer_model (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_period,
  output logic [7:0] o_count,
  output logic [1:0] o_presc,
  output logic o_restart
);
  // ==========================================
  // Time base
  // Restart marks the cycle the count is zero again
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {o_count, o_presc} <= 10'h000;
      o_restart <= 1'b0;
    end else if ({o_count, o_presc} == {i_period, 2'h3}) begin
      {o_count, o_presc} <= 10'h000;
      o_restart <= 1'b1;
    end else begin
      {o_count, o_presc} <= {o_count, o_presc} + 10'h001;
      o_restart <= 1'b0;
    end
  end
endmodule

/* File: dv/tb_pwm_duty_compare.sv */
// Testbench: register access and duty waveform checks of the modulator
`timescale 1ns/10ps
`define CHK(a, b) \
  begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_pwm_duty_compare;
  logic i_mclk, i_arst_n;
  logic [7:0] i_tmr1_count, i_period_timer_count_count, i_tmr3_count;
  logic [7:0] i_tmr1_period, i_period_timer_count_period, i_tmr3_period;
  logic [1:0] i_tmr1_presc, i_period_timer_count_presc, i_tmr3_presc;
  logic i_tmr1_restart, i_period_timer_count_restart, i_tmr3_restart;
  logic [5:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_chan_a, o_chan_b;
  logic [1:0] o_bresp, o_rresp;
  int errors, n_checks, c, i;
  int ex [4] = '{21, 21, 42, 28};

  // ==========================================
  // Design and timers
  pdc_top dut (.i_mclk, .i_arst_n, .i_tmr1_count, .i_tmr1_presc,
    .i_tmr1_period, .i_tmr1_restart, .i_period_timer_count_count, .i_period_timer_count_presc,
    .i_period_timer_count_period, .i_period_timer_count_restart, .i_tmr3_count, .i_tmr3_presc,
    .i_tmr3_period, .i_tmr3_restart, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .o_chan_a, .o_chan_b);
  pdc_timer_model t1 (.i_mclk, .i_arst_n, .i_period(i_tmr1_period),
    .o_count(i_tmr1_count), .o_presc(i_tmr1_presc),
    .o_restart(i_tmr1_restart));
  pdc_timer_model t2 (.i_mclk, .i_arst_n, .i_period(i_period_timer_count_period),
    .o_count(i_period_timer_count_count), .o_presc(i_period_timer_count_presc),
    .o_restart(i_period_timer_count_restart));
  pdc_timer_model t3 (.i_mclk, .i_arst_n, .i_period(i_tmr3_period),
    .o_count(i_tmr3_count), .o_presc(i_tmr3_presc),
    .o_restart(i_tmr3_restart));

  // ==========================================
  // Tasks
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic lim(input int k);
    if (k >= 50) begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    i_bready <= 1'b0;
    `CHK(o_bresp, pdc_pkg::RESP_OKAY)
    lim(k);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    int k;
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_mclk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    i_rready <= 1'b0;
    `CHK(o_rdata, {24'h000000, d})
    `CHK(o_rresp, r)
    lim(k);
  endtask

  // Window of 96 cycles spans whole periods of all three timers
  task automatic meas(input int ea, input int eb);
    int na, nb;
    na = 0;
    nb = 0;
    repeat (70) @(posedge i_mclk);
    repeat (96) begin
      @(negedge i_mclk);
      if (o_chan_a === 1'b1) na++;
      if (o_chan_b === 1'b1) nb++;
      if ($isunknown({o_chan_a, o_chan_b})) na += 1000;
    end
    `CHK(na, ea)
    `CHK(nb, eb)
  endtask

  // ==========================================
  // Stimulus
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    i_arst_n = 1'b0;
    i_awaddr = 6'h00;
    i_araddr = 6'h00;
    i_wdata = 32'h00000000;
    i_wstrb = 4'hf;
    i_tmr1_period = 8'h07;
    i_period_timer_count_period = 8'h03;
    i_tmr3_period = 8'h05;
    errors = 0;
    n_checks = 0;
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    rd(pdc_pkg::CTRL_A_OFF, 8'h00, pdc_pkg::RESP_OKAY);
    rd(pdc_pkg::TSEL_OFF, pdc_pkg::TSEL_RESET, pdc_pkg::RESP_OKAY);
    rd(pdc_pkg::CTRL_B_OFF, 8'h00, pdc_pkg::RESP_OKAY);
    rd(6'h20, 8'h00, pdc_pkg::RESP_SLVERR);
    wr(pdc_pkg::CTRL_A_OFF, 8'h7f);
    rd(pdc_pkg::CTRL_A_OFF, 8'h10, pdc_pkg::RESP_OKAY);
    wr(pdc_pkg::DUTY_HI_B_OFF, 8'ha5);
    rd(pdc_pkg::DUTY_HI_B_OFF, 8'ha5, pdc_pkg::RESP_OKAY);
    wr(pdc_pkg::DUTY_LO_B_OFF, 8'hff);
    rd(pdc_pkg::DUTY_LO_B_OFF, 8'hc0, pdc_pkg::RESP_OKAY);
    // Duty 7 on both channels, every select code
    wr(pdc_pkg::CTRL_A_OFF, 8'h80);
    wr(pdc_pkg::CTRL_B_OFF, 8'h80);
    wr(pdc_pkg::DUTY_HI_A_OFF, 8'h01);
    wr(pdc_pkg::DUTY_LO_A_OFF, 8'hff);
    rd(pdc_pkg::DUTY_LO_A_OFF, 8'hc0, pdc_pkg::RESP_OKAY);
    wr(pdc_pkg::DUTY_HI_B_OFF, 8'h01);
    for (c = 0; c < 4; c++) begin
      wr(pdc_pkg::TSEL_OFF, {c[1:0], c[1:0], 4'h0});
      meas(ex[c], ex[c]);
    end
    wr(pdc_pkg::TSEL_OFF, 8'h00);
    wr(pdc_pkg::DUTY_HI_A_OFF, 8'h03);
    wr(pdc_pkg::DUTY_LO_A_OFF, 8'h80);
    meas(42, 21);
    wr(pdc_pkg::CTRL_A_OFF, 8'h90);
    meas(54, 21);
    wr(pdc_pkg::CTRL_A_OFF, 8'h10);
    meas(0, 21);
    wr(pdc_pkg::CTRL_A_OFF, 8'h80);
    wr(pdc_pkg::DUTY_HI_A_OFF, 8'h07);
    wr(pdc_pkg::DUTY_LO_A_OFF, 8'h00);
    meas(96, 21);
    rd(pdc_pkg::CTRL_A_OFF, 8'ha0, pdc_pkg::RESP_OKAY);
    wr(pdc_pkg::DUTY_HI_A_OFF, 8'h00);
    meas(0, 21);
    wr(pdc_pkg::DUTY_HI_A_OFF, 8'h01);
    meas(12, 21);
    // New duty written mid-period must wait for the next restart
    for (i = 0; i < 50 && i_tmr1_restart !== 1'b1; i++)
      @(posedge i_mclk);
    lim(i);
    wr(pdc_pkg::DUTY_HI_A_OFF, 8'h04);
    repeat (6) @(posedge i_mclk);
    `CHK(o_chan_a, 1'b0)
    meas(48, 21);
    wrap_up();
  end
endmodule

/* File: logic/pdc_channel.sv */
// One modulator channel: duty buffer, compare and polarity
`timescale 1ns/10ps
module pdc_channel #(
  parameter int DW = 10
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic i_invert,
  input wire logic [DW-1:0] i_duty,
  input wire logic [DW-1:0] i_count,
  input wire logic [7:0] i_period,
  input wire logic i_restart,
  output logic o_level
);
  typedef struct packed {
    logic [DW-1:0] duty_buf;
    logic raw;
    logic level;
  } pdc_ch_t;
  pdc_ch_t st_reg;
  pdc_ch_t st_next;

  function automatic logic full_duty(input logic [DW-1:0] d,
                                     input logic [7:0] p);
    full_duty = d[DW-1:2] >= p;
  endfunction

  always_comb begin
    st_next = st_reg;
    if (i_restart) begin
      st_next.duty_buf = i_duty;
      st_next.raw = (i_duty != '0);
    end else if (st_reg.raw && i_count == st_reg.duty_buf &&
                 !full_duty(st_reg.duty_buf, i_period)) begin
      st_next.raw = 1'b0;
    end
    // Inversion after compare, disabled means inactive
    st_next.level = i_enable & (st_next.raw ^ i_invert);
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.level;

  property p_off_low;
    @(posedge i_mclk) disable iff (!i_arst_n)
      !i_enable |=> !o_level;
  endproperty
  a_off_low: assert property (p_off_low) else $error("disabled active");

  property p_zero_duty;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_restart && i_duty == '0 |=> !st_reg.raw;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty set");

  property p_latch;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_restart |=> st_reg.duty_buf == $past(i_duty);
  endproperty
  a_latch: assert property (p_latch) else $error("duty not latched");

  property p_hold_buf;
    @(posedge i_mclk) disable iff (!i_arst_n)
      !i_restart |=> $stable(st_reg.duty_buf);
  endproperty
  a_hold_buf: assert property (p_hold_buf) else $error("buffer moved");
endmodule

/* File: logic/pdc_pkg.sv */
// Package: register map, field positions and reset values of the modulator
package pdc_pkg;
  localparam logic [5:0] CTRL_A_OFF = 6'h00;
  localparam logic [5:0] DUTY_HI_A_OFF = 6'h04;
  localparam logic [5:0] DUTY_LO_A_OFF = 6'h08;
  localparam logic [5:0] CTRL_B_OFF = 6'h0c;
  localparam logic [5:0] DUTY_HI_B_OFF = 6'h10;
  localparam logic [5:0] DUTY_LO_B_OFF = 6'h14;
  localparam logic [5:0] TSEL_OFF = 6'h18;
  localparam logic [5:0] STATUS_OFF = 6'h1c;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_INV_BIT = 4;
  localparam int TSEL_B_LSB = 6;
  localparam int TSEL_A_LSB = 4;
  localparam int DLO_LSB = 6;
  localparam logic [7:0] TSEL_RESET = 8'h55;
  localparam logic [1:0] TB_SECOND = 2'h2;
  localparam logic [1:0] TB_THIRD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/pdc_top.sv */
// Two-channel 10-bit duty compare modulator with AXI4-Lite registers
// Function
// - Two channels, each with control and duty pair, sharing timer select.
// - Control bit 7 enables the channel.
// - Control bit 5 reads the present output level; writes ignored.
// - Control bit 4 set inverts the channel output.
// - Control bits 6 and 3..0 read zero and ignore writes.
// - Channel B select: 11 third timer, 10 second timer.
// - Channel A select: 11 third timer, 10 second timer.
// - High duty register holds duty bits 9..2.
// - Low duty register bits 7..6 hold duty bits 1..0; rest zero.
// - Output set at timer restart, cleared when count equals duty.
// - Duty at or above period never clears the output.
// - Duty registers buffered, loaded after timer hits period.
// - Zero duty keeps output inactive across restart.
`timescale 1ns/10ps
module pdc_top #(
  parameter int DW = 10
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // First timer
  input wire logic [7:0] i_tmr1_count,
  input wire logic [1:0] i_tmr1_presc,
  input wire logic [7:0] i_tmr1_period,
  input wire logic i_tmr1_restart,
  // Second timer
  input wire logic [7:0] i_period_timer_count_count,
  input wire logic [1:0] i_period_timer_count_presc,
  input wire logic [7:0] i_period_timer_count_period,
  input wire logic i_period_timer_count_restart,
  // Third timer
  input wire logic [7:0] i_tmr3_count,
  input wire logic [1:0] i_tmr3_presc,
  input wire logic [7:0] i_tmr3_period,
  input wire logic i_tmr3_restart,
  // AXI4-Lite
  input wire logic [5:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [5:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_chan_a,
  output logic o_chan_b
);
  typedef struct packed {
    logic [1:0] en;
    logic [1:0] inv;
    logic [7:0] dhi_a;
    logic [1:0] dlo_a;
    logic [7:0] dhi_b;
    logic [1:0] dlo_b;
    logic [7:0] tsel;
    logic aw_held;
    logic [5:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pdc_regs_t;
  pdc_regs_t st_reg;
  pdc_regs_t st_next;

  // ==========================================================
  // Time base selection
  typedef struct packed {
    logic [DW-1:0] count;
    logic [7:0] period;
    logic restart;
  } pdc_tb_t;

  // Timers come in as arguments so the selection follows every count change
  function automatic pdc_tb_t pick_tb(input logic [1:0] sel,
                                      input pdc_tb_t t1,
                                      input pdc_tb_t t2,
                                      input pdc_tb_t t3);
    pdc_tb_t r;
    unique case (sel)
      pdc_pkg::TB_THIRD: r = t3;
      pdc_pkg::TB_SECOND: r = t2;
      // Codes 00 and 01 both fall back to the first timer
      default: r = t1;
    endcase
    pick_tb = r;
  endfunction

  pdc_tb_t tb_1;
  pdc_tb_t tb_2;
  pdc_tb_t tb_3;
  pdc_tb_t tb_a;
  pdc_tb_t tb_b;
  logic lvl_a;
  logic lvl_b;
  assign tb_1 = {i_tmr1_count, i_tmr1_presc, i_tmr1_period, i_tmr1_restart};
  assign tb_2 = {i_period_timer_count_count, i_period_timer_count_presc, i_period_timer_count_period, i_period_timer_count_restart};
  assign tb_3 = {i_tmr3_count, i_tmr3_presc, i_tmr3_period, i_tmr3_restart};
  assign tb_a = pick_tb(st_reg.tsel[pdc_pkg::TSEL_A_LSB +: 2],
                        tb_1, tb_2, tb_3);
  assign tb_b = pick_tb(st_reg.tsel[pdc_pkg::TSEL_B_LSB +: 2],
                        tb_1, tb_2, tb_3);

  // ==========================================================
  // Channels
  pdc_channel #(.DW(DW)) u_chan_a (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_enable(st_reg.en[0]),
    .i_invert(st_reg.inv[0]),
    .i_duty({st_reg.dhi_a, st_reg.dlo_a}),
    .i_count(tb_a.count),
    .i_period(tb_a.period),
    .i_restart(tb_a.restart),
    .o_level(lvl_a)
  );
  pdc_channel #(.DW(DW)) u_chan_b (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_enable(st_reg.en[1]),
    .i_invert(st_reg.inv[1]),
    .i_duty({st_reg.dhi_b, st_reg.dlo_b}),
    .i_count(tb_b.count),
    .i_period(tb_b.period),
    .i_restart(tb_b.restart),
    .o_level(lvl_b)
  );

  // ==========================================================
  // Register read and write helpers
  function automatic logic [7:0] ctrl_view(input logic en, input logic inv,
                                           input logic lvl);
    logic [7:0] v;
    v = 8'h00;
    v[pdc_pkg::CTRL_EN_BIT] = en;
    v[pdc_pkg::CTRL_OUT_BIT] = lvl;
    v[pdc_pkg::CTRL_INV_BIT] = inv;
    ctrl_view = v;
  endfunction

  logic do_wr;
  logic do_rd;
  logic [7:0] rd_byte;
  logic rd_ok;
  assign do_wr = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  // Read data only after the address handshake, never ahead of it
  assign do_rd = i_arvalid && o_arready;

  always_comb begin
    rd_ok = 1'b1;
    unique case (i_araddr)
      pdc_pkg::CTRL_A_OFF:
        rd_byte = ctrl_view(st_reg.en[0], st_reg.inv[0], lvl_a);
      pdc_pkg::CTRL_B_OFF:
        rd_byte = ctrl_view(st_reg.en[1], st_reg.inv[1], lvl_b);
      pdc_pkg::DUTY_HI_A_OFF: rd_byte = st_reg.dhi_a;
      pdc_pkg::DUTY_LO_A_OFF:
        rd_byte = {st_reg.dlo_a, 6'h00};
      pdc_pkg::DUTY_HI_B_OFF: rd_byte = st_reg.dhi_b;
      pdc_pkg::DUTY_LO_B_OFF:
        rd_byte = {st_reg.dlo_b, 6'h00};
      pdc_pkg::TSEL_OFF: rd_byte = st_reg.tsel;
      pdc_pkg::STATUS_OFF: rd_byte = {6'h00, lvl_b, lvl_a};
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    if (i_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = i_awaddr;
    end
    if (i_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = i_wdata[7:0];
      st_next.w_strb0 = i_wstrb[0];
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = pdc_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        pdc_pkg::CTRL_A_OFF: if (st_reg.w_strb0) begin
          st_next.en[0] = st_reg.w_data[pdc_pkg::CTRL_EN_BIT];
          st_next.inv[0] = st_reg.w_data[pdc_pkg::CTRL_INV_BIT];
        end
        pdc_pkg::CTRL_B_OFF: if (st_reg.w_strb0) begin
          st_next.en[1] = st_reg.w_data[pdc_pkg::CTRL_EN_BIT];
          st_next.inv[1] = st_reg.w_data[pdc_pkg::CTRL_INV_BIT];
        end
        pdc_pkg::DUTY_HI_A_OFF:
          if (st_reg.w_strb0) st_next.dhi_a = st_reg.w_data;
        pdc_pkg::DUTY_LO_A_OFF: if (st_reg.w_strb0) begin
          st_next.dlo_a = st_reg.w_data[pdc_pkg::DLO_LSB +: 2];
        end
        pdc_pkg::DUTY_HI_B_OFF:
          if (st_reg.w_strb0) st_next.dhi_b = st_reg.w_data;
        pdc_pkg::DUTY_LO_B_OFF: if (st_reg.w_strb0) begin
          st_next.dlo_b = st_reg.w_data[pdc_pkg::DLO_LSB +: 2];
        end
        pdc_pkg::TSEL_OFF:
          if (st_reg.w_strb0) st_next.tsel = st_reg.w_data;
        // Status is read-only; writes answer okay and change nothing
        pdc_pkg::STATUS_OFF: st_next.bresp = pdc_pkg::RESP_OKAY;
        default: st_next.bresp = pdc_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (do_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = {24'h000000, rd_byte};
      st_next.rresp = rd_ok ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
      st_reg.tsel <= pdc_pkg::TSEL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  logic awready_reg;
  logic wready_reg;
  logic arready_reg;
  logic chan_a_reg;
  logic chan_b_reg;
  // Ready flops mirror free holding slots one cycle late
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      chan_a_reg <= 1'b0;
      chan_b_reg <= 1'b0;
    end else begin
      awready_reg <= i_awvalid && !st_reg.aw_held && !awready_reg;
      wready_reg <= i_wvalid && !st_reg.w_held && !wready_reg;
      arready_reg <= i_arvalid && !st_reg.rvalid && !arready_reg;
      chan_a_reg <= st_next.en[0] ? lvl_a : 1'b0;
      chan_b_reg <= st_next.en[1] ? lvl_b : 1'b0;
    end
  end
  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_arready = arready_reg;
  assign o_bvalid = st_reg.bvalid;
  assign o_bresp = st_reg.bresp;
  assign o_rvalid = st_reg.rvalid;
  assign o_rdata = st_reg.rdata;
  assign o_rresp = st_reg.rresp;
  assign o_chan_a = chan_a_reg;
  assign o_chan_b = chan_b_reg;

  // ==========================================================
  // Checks
  property p_rd_zero_bits;
    @(posedge i_mclk) disable iff (!i_arst_n)
      do_rd && i_araddr == pdc_pkg::CTRL_A_OFF |=>
        (o_rdata[6] == 1'b0) && (o_rdata[3:0] == 4'h0);
  endproperty
  a_rd_zero_bits: assert property (p_rd_zero_bits) else $error("rsv set");

  property p_rd_level;
    @(posedge i_mclk) disable iff (!i_arst_n)
      do_rd && i_araddr == pdc_pkg::CTRL_B_OFF |=> o_rdata[5] == $past(lvl_b);
  endproperty
  a_rd_level: assert property (p_rd_level) else $error("level read");

  property p_dlo_zero;
    @(posedge i_mclk) disable iff (!i_arst_n)
      do_rd && i_araddr == pdc_pkg::DUTY_LO_A_OFF |=> o_rdata[5:0] == 6'h00;
  endproperty
  a_dlo_zero: assert property (p_dlo_zero) else $error("low duty rsv");

  property p_en_write;
    @(posedge i_mclk) disable iff (!i_arst_n)
      do_wr && st_reg.aw_addr == pdc_pkg::CTRL_A_OFF && st_reg.w_strb0 |=>
        st_reg.en[0] == $past(st_reg.w_data[7]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable lost");

  property p_sel_third;
    @(posedge i_mclk) disable iff (!i_arst_n)
      st_reg.tsel[7:6] == pdc_pkg::TB_THIRD |-> tb_b.restart == i_tmr3_restart;
  endproperty
  a_sel_third: assert property (p_sel_third) else $error("b timer");

  property p_sel_second;
    @(posedge i_mclk) disable iff (!i_arst_n)
      st_reg.tsel[5:4] == pdc_pkg::TB_SECOND |->
        tb_a.count == {i_period_timer_count_count, i_period_timer_count_presc};
  endproperty
  a_sel_second: assert property (p_sel_second) else $error("a timer");

  property p_inv_write;
    @(posedge i_mclk) disable iff (!i_arst_n)
      do_wr && st_reg.aw_addr == pdc_pkg::CTRL_B_OFF && st_reg.w_strb0 |=>
        st_reg.inv[1] == $past(st_reg.w_data[pdc_pkg::CTRL_INV_BIT]);
  endproperty
  a_inv_write: assert property (p_inv_write) else $error("inv lost");

  property p_chan_off;
    @(posedge i_mclk) disable iff (!i_arst_n)
      !st_reg.en[0] && !$past(st_reg.en[0]) |=> !o_chan_a;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("off but high");

  property p_rd_answer;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_arvalid && o_arready |=> o_rvalid && !o_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");

  property p_wr_answer;
    @(posedge i_mclk) disable iff (!i_arst_n)
      do_wr |=> o_bvalid && !o_awready && !o_wready;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write answer");

  c_invert: cover property (@(posedge i_mclk) st_reg.inv[0] && o_chan_a);
  c_write: cover property (@(posedge i_mclk) do_wr);
  c_read: cover property (@(posedge i_mclk) do_rd);
  c_pulse: cover property (@(posedge i_mclk) $fell(o_chan_a));
endmodule
